// file: ctx_bus_model.sv
`default_nettype none
module ctx_bus_model (
   input  wire logic line_a,
   input  wire logic line_a_oe_n,
   input  wire logic line_b,
   input  wire logic line_b_oe_n,
   input  wire logic clock_on_b,
   input  wire logic other_dominant,
   output logic      bus_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dom_a;
   logic dom_b;
   // a floating line reads recessive through the termination
   assign dom_a = !line_a_oe_n && !line_a;
   // in normal mode 2 line b is a clock, so it carries no bus level
   assign dom_b = !line_b_oe_n && !line_b && !clock_on_b;
   assign bus_level = !(dom_a || dom_b || other_dominant);
endmodule // ctx_bus_model
`default_nettype wire

// file: ctx_pkg.sv
`default_nettype none
package ctx_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_OUT_CTRL  = 8'h28;
   localparam logic [7:0] ADDR_TX_ID_HI  = 8'h2A;
   localparam logic [7:0] ADDR_TX_ID_LO  = 8'h2B;
   localparam logic [7:0] ADDR_TX_PAY0   = 8'h2C;
   localparam logic [7:0] ADDR_TX_PAY7   = 8'h33;
   localparam logic [7:0] ADDR_RX_ID_HI  = 8'h34;
   localparam logic [7:0] ADDR_RX_CTL    = 8'h35;
   localparam logic [7:0] ADDR_RX_PAY0   = 8'h36;
   localparam logic [7:0] ADDR_RX_PAY7   = 8'h3D;
   localparam logic [7:0] ADDR_CMD_STAT  = 8'h3E;
   localparam int         PAY_BYTES      = 8;
   localparam int         RX_SETS        = 2;
   localparam logic [7:0] RESET_BYTE     = 8'h00;

   // output_driver_control fields
   localparam int OC_MODE_LSB = 0;
   localparam int LINE_A_LSB  = 2;
   localparam int LINE_STRIDE = 3;
   localparam int POL_OFS     = 0;
   localparam int NEN_OFS     = 1;
   localparam int PEN_OFS     = 2;

   // tx_identifier_low_rtr_length fields
   localparam int ID_LO_LSB = 5;
   localparam int RTR_POS   = 4;
   localparam int DLC_LSB   = 0;
   localparam logic [3:0] DLC_MAX = 4'h8;

   // command (write) and status (read) bits
   localparam int CMD_TX_REQ     = 0;
   localparam int CMD_RX_RELEASE = 1;
   localparam int CMD_CLR_FLAGS  = 2;
   localparam int ST_TX_BUSY     = 0;
   localparam int ST_ARB_LOST    = 1;
   localparam int ST_RX_FULL     = 2;
   localparam int ST_OVERRUN     = 3;
   localparam int ST_TX_DONE     = 4;

   // timing: one bit-timing clock period and the bit layout in those units
   localparam int CLK_NS     = 10;
   localparam int TQ_NS      = 100;
   localparam int TQ_DIV     = (TQ_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] TQ_DIV_LAST = 4'(TQ_DIV - 1);
   localparam logic [3:0] TQ_PER_BIT_LAST = 4'h9;
   localparam logic [3:0] SAMPLE_TQ  = 4'h6;
   localparam logic [3:0] SYNC_TQ    = 4'h0;
   localparam logic [2:0] EOF_LAST   = 3'h6;

   // frame layout: start, 11 id, rtr, 2 reserved, 4 length, 64 payload
   localparam int FRAME_MAX = 83;
   localparam logic [6:0] ARB_BITS = 7'h0D;
   localparam logic [6:0] HDR_BITS = 7'h13;

   typedef enum logic [1:0] {
      MODE_BIPHASE = 2'b00,
      MODE_UNUSED  = 2'b01,
      MODE_NORMAL1 = 2'b10,
      MODE_NORMAL2 = 2'b11
   } ctx_mode_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_EOF  = 2'b11
   } ctx_tx_state_t;

   typedef struct packed {
      logic [7:0]  id_hi;
      logic [7:0]  ctl;
      logic [63:0] data;
   } ctx_rx_msg_t;
endpackage
`default_nettype wire

// file: ctx_tx_core.sv
// Function
// - mode field: biphase, unused, normal 1, normal 2
// - dominant is 0, recessive is 1 internally
// - biphase toggle drives line a, complement b
// - biphase recessive bits float both lines
// - normal 1 sends same bit both lines
// - normal 2 line b carries bit clock
// - bit clock high during sync segment
// - per-line P and N driver enables
// - level is data xor polarity, gates drivers
// - each line has its own polarity bit
// - 11-bit id split, msb sent first
// - smallest identifier wins arbitration
// - remote bit selects remote or data frame
// - remote frame sends zero data bytes
// - length code gives byte count up to 8
// - send first n payload bytes only
// - rx id high register matches tx layout
// - two receive sets behind one window
// - store accepted message in free set, else overrun
// - dominant wins on bus, used by arbitration
//
// The strobed register port is this design's own decision.
`default_nettype none
module ctx_tx_core (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 reset_request,
   input  wire logic                 bus_in,
   input  wire logic                 rx_msg_valid,
   input  wire ctx_pkg::ctx_rx_msg_t rx_msg,
   output logic                      bus_out_a,
   output logic                      bus_out_a_oe_n,
   output logic                      bus_out_b,
   output logic                      bus_out_b_oe_n,
   output logic                      rx_overrun
);

   logic [7:0]                 ctrl_reg;
   logic [7:0]                 id_hi_reg;
   logic [7:0]                 id_lo_reg;
   logic [7:0]                 pay_reg [ctx_pkg::PAY_BYTES];
   ctx_pkg::ctx_rx_msg_t       rx_buf_reg [ctx_pkg::RX_SETS];
   logic [ctx_pkg::RX_SETS-1:0] rx_full_reg;
   logic                       rx_wr_sel_reg;
   logic                       rx_rd_sel_reg;
   logic                       overrun_reg;
   logic                       arb_lost_reg;
   logic                       tx_done_reg;
   logic                       tx_pend_reg;
   logic [3:0]                 div_reg;
   logic [3:0]                 tq_idx_reg;
   logic                       bus_meta_reg;
   logic                       bus_sync_reg;
   ctx_pkg::ctx_tx_state_t     state_reg;
   logic [ctx_pkg::FRAME_MAX-1:0] frame_reg;
   logic [6:0]                 bits_left_reg;
   logic [6:0]                 bit_pos_reg;
   logic [2:0]                 eof_cnt_reg;
   logic                       cur_bit_reg;
   logic                       lose_reg;
   logic                       bit_start_reg;
   logic                       tog_reg;
   logic [1:0]                 out_reg;
   logic [1:0]                 oe_n_reg;
   logic [7:0]                 rdata_reg;

   logic                       tq_en;
   logic                       bit_tick;
   logic                       sample_tick;
   logic                       wr_cmd;
   logic                       tx_start;
   logic                       tx_done_set;
   logic                       rx_release;
   logic                       rx_store;
   logic [3:0]                 dlc;
   logic [3:0]                 nbytes;
   logic [63:0]                pay_flat;
   logic [ctx_pkg::FRAME_MAX-1:0] frame_load;
   logic [6:0]                 total_bits;
   ctx_pkg::ctx_mode_t         mode;
   logic                       tog_eff;
   logic [1:0]                 line_d;
   logic                       drv_off;
   ctx_pkg::ctx_rx_msg_t       rx_view;

   // register bus
   assign wr_cmd     = reg_wr && (reg_addr == ctx_pkg::ADDR_CMD_STAT);
   assign rx_release = wr_cmd && reg_wdata[ctx_pkg::CMD_RX_RELEASE]
                       && rx_full_reg[rx_rd_sel_reg];
   assign rx_view    = rx_buf_reg[rx_rd_sel_reg];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl_reg <= ctx_pkg::RESET_BYTE;
      else if (reg_wr && reg_addr == ctx_pkg::ADDR_OUT_CTRL && reset_request)
         ctrl_reg <= reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         id_hi_reg <= ctx_pkg::RESET_BYTE;
         id_lo_reg <= ctx_pkg::RESET_BYTE;
      end
      else if (reg_wr && reg_addr == ctx_pkg::ADDR_TX_ID_HI)
         id_hi_reg <= reg_wdata;
      else if (reg_wr && reg_addr == ctx_pkg::ADDR_TX_ID_LO)
         id_lo_reg <= reg_wdata;
   end

   genvar gi;
   generate
      for (gi = 0; gi < ctx_pkg::PAY_BYTES; gi++)
      begin : g_pay
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               pay_reg[gi] <= ctx_pkg::RESET_BYTE;
            else if (reg_wr && reg_addr == ctx_pkg::ADDR_TX_PAY0 + 8'(gi))
               pay_reg[gi] <= reg_wdata;
         end
         // byte 1 sits in the top bits so it leaves first
         assign pay_flat[63-8*gi -: 8] = pay_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_reg <= ctx_pkg::RESET_BYTE;
      else if (reg_rd)
      begin
         if (reg_addr == ctx_pkg::ADDR_OUT_CTRL)
            rdata_reg <= reset_request ? ctrl_reg : ctx_pkg::RESET_BYTE;
         else if (reg_addr == ctx_pkg::ADDR_TX_ID_HI)
            rdata_reg <= id_hi_reg;
         else if (reg_addr == ctx_pkg::ADDR_TX_ID_LO)
            rdata_reg <= id_lo_reg;
         else if (reg_addr >= ctx_pkg::ADDR_TX_PAY0
                  && reg_addr <= ctx_pkg::ADDR_TX_PAY7)
            rdata_reg <= pay_reg[3'(reg_addr - ctx_pkg::ADDR_TX_PAY0)];
         else if (reg_addr == ctx_pkg::ADDR_RX_ID_HI)
            rdata_reg <= rx_view.id_hi;
         else if (reg_addr == ctx_pkg::ADDR_RX_CTL)
            rdata_reg <= rx_view.ctl;
         else if (reg_addr >= ctx_pkg::ADDR_RX_PAY0
                  && reg_addr <= ctx_pkg::ADDR_RX_PAY7)
            rdata_reg <= rx_view.data[63-8*int'(3'(reg_addr
                         - ctx_pkg::ADDR_RX_PAY0)) -: 8];
         else if (reg_addr == ctx_pkg::ADDR_CMD_STAT)
            rdata_reg <= {3'b000, tx_done_reg, overrun_reg,
                          rx_full_reg[rx_rd_sel_reg], arb_lost_reg,
                          state_reg != ctx_pkg::TX_IDLE || tx_pend_reg};
         else
            rdata_reg <= ctx_pkg::RESET_BYTE;
      end
      else
         rdata_reg <= ctx_pkg::RESET_BYTE;
   end

   // receive buffer sets
   assign rx_store = rx_msg_valid && !rx_full_reg[rx_wr_sel_reg];

   generate
      for (gi = 0; gi < ctx_pkg::RX_SETS; gi++)
      begin : g_rx
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               rx_full_reg[gi] <= 1'b0;
            else if (rx_store && rx_wr_sel_reg == 1'(gi))
               rx_full_reg[gi] <= 1'b1;
            else if (rx_release && rx_rd_sel_reg == 1'(gi))
               rx_full_reg[gi] <= 1'b0;
         end
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               rx_buf_reg[gi] <= '0;
            else if (rx_store && rx_wr_sel_reg == 1'(gi))
               rx_buf_reg[gi] <= rx_msg;
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_wr_sel_reg <= 1'b0;
         rx_rd_sel_reg <= 1'b0;
      end
      else
      begin
         if (rx_store)
            rx_wr_sel_reg <= ~rx_wr_sel_reg;
         if (rx_release)
            rx_rd_sel_reg <= ~rx_rd_sel_reg;
      end
   end

   // overrun set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         overrun_reg <= 1'b0;
      else if (rx_msg_valid && rx_full_reg[rx_wr_sel_reg])
         overrun_reg <= 1'b1;
      else if (wr_cmd && reg_wdata[ctx_pkg::CMD_CLR_FLAGS])
         overrun_reg <= 1'b0;
   end

   // bit-timing clock and bit position
   assign tq_en       = (div_reg == ctx_pkg::TQ_DIV_LAST);
   assign bit_tick    = tq_en && tq_idx_reg == ctx_pkg::TQ_PER_BIT_LAST;
   assign sample_tick = tq_en && tq_idx_reg == ctx_pkg::SAMPLE_TQ;

   always_ff @(posedge clk)
   begin
      if (sys_rst || tq_en)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || bit_tick)
         tq_idx_reg <= ctx_pkg::SYNC_TQ;
      else if (tq_en)
         tq_idx_reg <= tq_idx_reg + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bus_meta_reg <= 1'b1;
         bus_sync_reg <= 1'b1;
      end
      else
      begin
         bus_meta_reg <= bus_in;
         bus_sync_reg <= bus_meta_reg;
      end
   end

   // frame assembly
   assign dlc    = id_lo_reg[ctx_pkg::DLC_LSB +: 4];
   assign nbytes = id_lo_reg[ctx_pkg::RTR_POS] ? 4'h0
                   : (dlc > ctx_pkg::DLC_MAX ? ctx_pkg::DLC_MAX : dlc);
   assign total_bits = ctx_pkg::HDR_BITS + {nbytes, 3'b000};
   assign frame_load = {1'b0, id_hi_reg, id_lo_reg[ctx_pkg::ID_LO_LSB +: 3],
                        id_lo_reg[ctx_pkg::RTR_POS], 2'b00, dlc, pay_flat};

   assign tx_start    = bit_tick && state_reg == ctx_pkg::TX_IDLE
                        && tx_pend_reg;
   assign tx_done_set = bit_tick && state_reg == ctx_pkg::TX_EOF
                        && eof_cnt_reg == ctx_pkg::EOF_LAST;

   // a request is only taken while idle and out of reset request
   always_ff @(posedge clk)
   begin
      if (sys_rst || reset_request)
         tx_pend_reg <= 1'b0;
      else if (wr_cmd && reg_wdata[ctx_pkg::CMD_TX_REQ]
               && state_reg == ctx_pkg::TX_IDLE)
         tx_pend_reg <= 1'b1;
      else if (tx_start)
         tx_pend_reg <= 1'b0;
   end

   // recessive sent but dominant seen means a lower id is out there
   always_ff @(posedge clk)
   begin
      if (sys_rst || bit_tick)
         lose_reg <= 1'b0;
      else if (sample_tick && state_reg == ctx_pkg::TX_SEND
               && bit_pos_reg < ctx_pkg::ARB_BITS
               && cur_bit_reg && !bus_sync_reg)
         lose_reg <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg     <= ctx_pkg::TX_IDLE;
         cur_bit_reg   <= 1'b1;
         frame_reg     <= '0;
         bits_left_reg <= 7'h00;
         bit_pos_reg   <= 7'h00;
         eof_cnt_reg   <= 3'h0;
      end
      else if (bit_tick)
      begin
         case (state_reg)
            ctx_pkg::TX_IDLE:
            begin
               if (tx_pend_reg)
               begin
                  cur_bit_reg   <= frame_load[ctx_pkg::FRAME_MAX-1];
                  frame_reg     <= frame_load << 1;
                  bits_left_reg <= total_bits - 7'h01;
                  bit_pos_reg   <= 7'h00;
                  state_reg     <= ctx_pkg::TX_SEND;
               end
               else
                  cur_bit_reg <= 1'b1;
            end
            ctx_pkg::TX_SEND:
            begin
               if (lose_reg)
               begin
                  cur_bit_reg <= 1'b1;
                  state_reg   <= ctx_pkg::TX_IDLE;
               end
               else if (bits_left_reg == 7'h00)
               begin
                  cur_bit_reg <= 1'b1;
                  eof_cnt_reg <= 3'h0;
                  state_reg   <= ctx_pkg::TX_EOF;
               end
               else
               begin
                  cur_bit_reg   <= frame_reg[ctx_pkg::FRAME_MAX-1];
                  frame_reg     <= frame_reg << 1;
                  bits_left_reg <= bits_left_reg - 7'h01;
                  bit_pos_reg   <= bit_pos_reg + 7'h01;
               end
            end
            ctx_pkg::TX_EOF:
            begin
               cur_bit_reg <= 1'b1;
               eof_cnt_reg <= eof_cnt_reg + 3'h1;
               if (eof_cnt_reg == ctx_pkg::EOF_LAST)
                  state_reg <= ctx_pkg::TX_IDLE;
            end
            default:
            begin
               cur_bit_reg <= 1'b1;
               state_reg   <= ctx_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // sticky transmit flags, set wins over clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         arb_lost_reg <= 1'b0;
         tx_done_reg  <= 1'b0;
      end
      else
      begin
         if (bit_tick && state_reg == ctx_pkg::TX_SEND && lose_reg)
            arb_lost_reg <= 1'b1;
         else if (wr_cmd && reg_wdata[ctx_pkg::CMD_CLR_FLAGS])
            arb_lost_reg <= 1'b0;
         if (tx_done_set)
            tx_done_reg <= 1'b1;
         else if (wr_cmd && reg_wdata[ctx_pkg::CMD_CLR_FLAGS])
            tx_done_reg <= 1'b0;
      end
   end

   // biphase toggle flips once at the start of each dominant bit
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bit_start_reg <= 1'b0;
         tog_reg       <= 1'b1;
      end
      else
      begin
         bit_start_reg <= bit_tick;
         tog_reg       <= tog_eff;
      end
   end

   // tog_eff looks ahead so biphase pins line up with the other modes
   assign tog_eff = (bit_start_reg && !cur_bit_reg) ? ~tog_reg : tog_reg;
   assign mode    = ctx_pkg::ctx_mode_t'(ctrl_reg[ctx_pkg::OC_MODE_LSB +: 2]);

   always_comb
   begin
      line_d  = {cur_bit_reg, cur_bit_reg};
      drv_off = 1'b0;
      case (mode)
         ctx_pkg::MODE_BIPHASE:
         begin
            line_d  = {~tog_eff, tog_eff};
            drv_off = cur_bit_reg;
         end
         ctx_pkg::MODE_NORMAL1:
            line_d = {cur_bit_reg, cur_bit_reg};
         ctx_pkg::MODE_NORMAL2:
            line_d = {tq_idx_reg == ctx_pkg::SYNC_TQ, cur_bit_reg};
         default:
            drv_off = 1'b1;
      endcase
   end

   // per-line driver stage; P drives high, N drives low, neither floats
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_line
         localparam int BASE = ctx_pkg::LINE_A_LSB + ctx_pkg::LINE_STRIDE*gi;
         logic eff;
         logic p_on;
         logic n_on;
         assign eff  = line_d[gi] ^ ctrl_reg[BASE + ctx_pkg::POL_OFS];
         assign p_on = !drv_off && eff
                       && ctrl_reg[BASE + ctx_pkg::PEN_OFS];
         assign n_on = !drv_off && !eff
                       && ctrl_reg[BASE + ctx_pkg::NEN_OFS];
         always_ff @(posedge clk)
         begin
            if (sys_rst)
            begin
               out_reg[gi]  <= 1'b0;
               oe_n_reg[gi] <= 1'b1;
            end
            else
            begin
               out_reg[gi]  <= p_on;
               oe_n_reg[gi] <= !(p_on || n_on);
            end
         end
      end
   endgenerate

   assign reg_rdata      = rdata_reg;
   assign bus_out_a      = out_reg[0];
   assign bus_out_a_oe_n = oe_n_reg[0];
   assign bus_out_b      = out_reg[1];
   assign bus_out_b_oe_n = oe_n_reg[1];
   assign rx_overrun     = overrun_reg;

endmodule // ctx_tx_core
`default_nettype wire

// file: ctx_tx_core_props.sv
`default_nettype none
module ctx_tx_core_props (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reset_request,
   input wire logic        bus_in,
   input wire logic        rx_msg_valid,
   input wire logic [79:0] rx_msg,
   input wire logic        bus_out_a,
   input wire logic        bus_out_a_oe_n,
   input wire logic        bus_out_b,
   input wire logic        bus_out_b_oe_n,
   input wire logic        rx_overrun
);
   logic [7:0] oc_reg;
   logic [2:0] age_reg;
   logic       oc_wr;
   logic       settled;
   logic [1:0] md;
   logic       pp_both;
   assign oc_wr   = reg_wr && reg_addr == ctx_pkg::ADDR_OUT_CTRL;
   assign settled = age_reg == 3'h7;
   assign md      = oc_reg[1:0];
   assign pp_both = oc_reg[7:6] == 2'h3 && oc_reg[4:3] == 2'h3;

   // driver control shadow; pin checks wait until settled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         oc_reg <= 8'h00;
      else if (oc_wr && reset_request)
         oc_reg <= reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || oc_wr)
         age_reg <= 3'h0;
      else if (!settled)
         age_reg <= age_reg + 3'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_drv_a;
      settled && !bus_out_a_oe_n |-> (bus_out_a ? oc_reg[4] : oc_reg[3]);
   endproperty
   a_drv_a: assert property (p_drv_a)
      else $error("line a disabled driver on");
   property p_drv_b;
      settled && !bus_out_b_oe_n |-> (bus_out_b ? oc_reg[7] : oc_reg[6]);
   endproperty
   a_drv_b: assert property (p_drv_b)
      else $error("line b disabled driver on");
   property p_unused;
      settled && md == 2'h1 |-> bus_out_a_oe_n && bus_out_b_oe_n;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused mode drives a line");
   property p_biph_float;
      settled && md == 2'h0 && pp_both |-> bus_out_a_oe_n == bus_out_b_oe_n;
   endproperty
   a_biph_float: assert property (p_biph_float)
      else $error("biphase float mismatch");
   property p_biph_alt;
      settled && md == 2'h0 && pp_both && oc_reg[2] == oc_reg[5]
         && !bus_out_a_oe_n |-> bus_out_a != bus_out_b;
   endproperty
   a_biph_alt: assert property (p_biph_alt)
      else $error("biphase not complementary");
   property p_norm1;
      settled && md == 2'h2 && pp_both |-> !bus_out_a_oe_n
         && (bus_out_a ^ bus_out_b) == (oc_reg[2] ^ oc_reg[5]);
   endproperty
   a_norm1: assert property (p_norm1)
      else $error("normal mode 1 lines disagree");
   property p_clk_high;
      disable iff (sys_rst || !settled)
      md == 2'h3 && oc_reg[7:5] == 3'h6 && $rose(bus_out_b)
         |-> bus_out_b[*8] ##1 bus_out_b ##1 bus_out_b ##1 !bus_out_b;
   endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("bit clock pulse width");
   property p_clk_per;
      disable iff (sys_rst || !settled)
      md == 2'h3 && oc_reg[7:5] == 3'h6 && $rose(bus_out_b)
         |-> ##100 $rose(bus_out_b);
   endproperty
   a_clk_per: assert property (p_clk_per)
      else $error("bit clock period");
   property p_ovr;
      $rose(rx_overrun) |-> $past(rx_msg_valid);
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("overrun without message");
   property p_oc_rd;
      reg_rd && reg_addr == ctx_pkg::ADDR_OUT_CTRL
         |=> reg_rdata == ($past(reset_request) ? oc_reg : 8'h00);
   endproperty
   a_oc_rd: assert property (p_oc_rd)
      else $error("driver control read value");
endmodule // ctx_tx_core_props

bind ctx_tx_core ctx_tx_core_props u_props (
   .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .reset_request, .bus_in, .rx_msg_valid, .rx_msg(rx_msg), .bus_out_a,
   .bus_out_a_oe_n, .bus_out_b, .bus_out_b_oe_n, .rx_overrun
);
`default_nettype wire

// file: ctx_tx_core_tb_top.sv
`default_nettype none
module ctx_tx_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] PAY = 64'hA55A_0FF0_C33C_1EE1;
   logic clk, sys_rst, reg_wr, reg_rd, reset_request, bus_in, rx_msg_valid;
   logic out_a, oe_a_n, out_b, oe_b_n, rx_overrun, clock_on_b, other_dom;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic [3:0] pins;
   logic [7:0] oc_tab [6];
   logic [3:0] pin_tab [6];
   ctx_pkg::ctx_rx_msg_t rx_msg;
   int err_count, checked;
   assign pins = {oe_a_n, oe_a_n | out_a, oe_b_n, oe_b_n | out_b};

   ctx_tx_core DUT (
      .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reset_request, .bus_in, .rx_msg_valid, .rx_msg, .rx_overrun,
      .bus_out_a(out_a), .bus_out_a_oe_n(oe_a_n), .bus_out_b(out_b),
      .bus_out_b_oe_n(oe_b_n)
   );
   ctx_bus_model u_bus (
      .line_a(out_a), .line_a_oe_n(oe_a_n), .line_b(out_b),
      .line_b_oe_n(oe_b_n), .clock_on_b(clock_on_b),
      .other_dominant(other_dom), .bus_level(bus_in)
   );

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [95:0] e, g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [7:0] m, e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
      cmp(nm, 96'(e), 96'(rv & m));
   endtask

   task automatic rx_put(input logic [7:0] id);
      @(posedge clk);
      rx_msg_valid <= 1'b1;
      rx_msg <= '{id_hi: id, ctl: 8'h08, data: {8{id}}};
      @(posedge clk);
      rx_msg_valid <= 1'b0;
   endtask

   task automatic wait_sof();
      int n;
      n = 0;
      while (!(oe_a_n === 1'b0 && out_a === 1'b0) && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 400)
      begin
         err_count++;
         $display("Error start bit expected 0 seen timeout");
         wrap_up();
      end
   endtask

   task automatic frame(input logic [10:0] id, input logic rtr,
                        input logic [3:0] dlc);
      int nb;
      logic [95:0] e;
      logic [95:0] g;
      nb = 19 + (rtr ? 0 : 8 * int'(dlc));
      e = {1'b0, id, rtr, 2'h0, dlc, PAY, 13'h0000};
      g = '0;
      for (int i = nb; i < 96; i++)
         e[95 - i] = i < nb + 7;
      wr(ctx_pkg::ADDR_TX_ID_HI, id[10:3]);
      wr(ctx_pkg::ADDR_TX_ID_LO, {id[2:0], rtr, dlc});
      wr(ctx_pkg::ADDR_CMD_STAT, 8'h01);
      wait_sof();
      repeat (50) @(posedge clk);
      for (int i = 0; i < nb + 7; i++)
      begin
         g[95 - i] = out_a;
         repeat (100) @(posedge clk);
      end
      cmp("frame bits", e, g);
      rdc("tx status", ctx_pkg::ADDR_CMD_STAT, 8'h11, 8'h10);
      wr(ctx_pkg::ADDR_CMD_STAT, 8'h04);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reset_request = 1'b1;
      rx_msg_valid = 1'b0;
      rx_msg = '0;
      clock_on_b = 1'b0;
      other_dom = 1'b0;
      err_count = 0;
      checked = 0;
      oc_tab = '{8'hD8, 8'hD9, 8'hDA, 8'hDE, 8'h52, 8'hAE};
      pin_tab = '{4'hF, 4'hF, 4'h5, 4'h1, 4'h7, 4'h3};
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      wr(ctx_pkg::ADDR_OUT_CTRL, 8'hDB);
      rdc("out ctrl", ctx_pkg::ADDR_OUT_CTRL, 8'hFF, 8'hDB);
      @(posedge clk);
      reset_request <= 1'b0;
      wr(ctx_pkg::ADDR_OUT_CTRL, 8'h00);
      rdc("out ctrl locked", ctx_pkg::ADDR_OUT_CTRL, 8'hFF, 8'h00);
      @(posedge clk);
      reset_request <= 1'b1;
      rdc("out ctrl kept", ctx_pkg::ADDR_OUT_CTRL, 8'hFF, 8'hDB);
      for (int k = 0; k < 8; k++)
         wr(ctx_pkg::ADDR_TX_PAY0 + 8'(k), PAY[63 - 8 * k -: 8]);
      rdc("payload 8", ctx_pkg::ADDR_TX_PAY7, 8'hFF, PAY[7:0]);
      wr(ctx_pkg::ADDR_TX_ID_LO, 8'hB4);
      rdc("id low", ctx_pkg::ADDR_TX_ID_LO, 8'hFF, 8'hB4);
      rdc("unmapped", 8'h40, 8'hFF, 8'h00);
      $display("test registers done");
      for (int k = 0; k < 6; k++)
      begin
         wr(ctx_pkg::ADDR_OUT_CTRL, oc_tab[k]);
         repeat (8) @(posedge clk);
         cmp("pins", 96'(pin_tab[k]), 96'(pins));
      end
      $display("test drivers done");
      wr(ctx_pkg::ADDR_OUT_CTRL, 8'hD8);
      @(posedge clk);
      reset_request <= 1'b0;
      other_dom <= 1'b1;
      wr(ctx_pkg::ADDR_TX_ID_HI, 8'h1F);
      wr(ctx_pkg::ADDR_TX_ID_LO, 8'hE0);
      wr(ctx_pkg::ADDR_CMD_STAT, 8'h01);
      wait_sof();
      repeat (50) @(posedge clk);
      cmp("first dominant", 96'h1, 96'({out_a, out_b}));
      repeat (100) @(posedge clk);
      cmp("second dominant", 96'h2, 96'({out_a, out_b}));
      repeat (600) @(posedge clk);
      other_dom <= 1'b0;
      rdc("arb status", ctx_pkg::ADDR_CMD_STAT, 8'h03, 8'h02);
      cmp("released pins", 96'hF, 96'(pins));
      wr(ctx_pkg::ADDR_CMD_STAT, 8'h04);
      $display("test arbitration done");
      rx_put(8'h5A);
      rx_put(8'h3C);
      rdc("rx id", ctx_pkg::ADDR_RX_ID_HI, 8'hFF, 8'h5A);
      cmp("overrun idle", 96'h0, 96'(rx_overrun));
      rx_put(8'h77);
      #1;
      cmp("overrun", 96'h1, 96'(rx_overrun));
      rdc("rx id kept", ctx_pkg::ADDR_RX_ID_HI, 8'hFF, 8'h5A);
      wr(ctx_pkg::ADDR_CMD_STAT, 8'h02);
      rdc("rx id next", ctx_pkg::ADDR_RX_ID_HI, 8'hFF, 8'h3C);
      $display("test receive done");
      @(posedge clk);
      reset_request <= 1'b1;
      wr(ctx_pkg::ADDR_OUT_CTRL, 8'hDB);
      @(posedge clk);
      reset_request <= 1'b0;
      clock_on_b <= 1'b1;
      frame(11'h5A3, 1'b0, 4'h1);
      frame(11'h123, 1'b1, 4'h5);
      frame(11'h7F0, 1'b0, 4'h8);
      frame(11'h000, 1'b0, 4'h0);
      $display("test frames done");
      wrap_up();
   end
endmodule // ctx_tx_core_tb_top
`default_nettype wire
